// ### vpw_pkg.sv
// constants, field layout, request carrier and state encoding for the
// pci direct access window bridge; assumes one 20 MHz system clock.
package vpw_pkg;

  localparam logic [31:0] VPW_CTRL_OFS   = 32'h0000_0460;
  localparam logic [31:0] VPW_STAT_OFS   = 32'h0000_0464;
  localparam logic [31:0] VPW_WIN_BASE   = 32'h0000_2000;
  localparam int          VPW_WIN_AW     = 13;
  localparam logic [31:0] VPW_CTRL_MASK  = 32'hFFFF_EBF6;
  localparam logic [31:0] VPW_CTRL_RST   = 32'h0000_0000;
  localparam int          VPW_BASE_LSB   = 13;
  localparam int          VPW_FORCE_BIT  = 11;
  localparam int          VPW_LOWA_LSB   = 8;
  localparam int          VPW_RBE_LSB    = 4;
  localparam int          VPW_TYPE_LSB   = 1;
  localparam logic        VPW_MEN_RST    = 1'b1;
  localparam logic [7:0]  VPW_WAIT_CYCLES = 8'h20;

  localparam logic [1:0]  VPW_SZ_BYTE    = 2'h0;
  localparam logic [1:0]  VPW_SZ_WORD    = 2'h1;
  localparam logic [1:0]  VPW_SZ_LONG    = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic [31:0] wdata;
    logic        we;
  } vpw_req_t;

  localparam vpw_req_t VPW_REQ_RST = '{addr: 32'h0, cmd: 4'h0, be_n: 4'hF, wdata: 32'h0, we: 1'b0};

  typedef enum logic [2:0] {
    VPW_ST_IDLE = 3'h0,
    VPW_ST_REQ  = 3'h1,
    VPW_ST_ADDR = 3'h3,
    VPW_ST_DATA = 3'h2,
    VPW_ST_TURN = 3'h6
  } vpw_state_t;

endpackage

// ### vpw_pci_master.sv
// single data phase pci master engine for the direct access window.
// assumes the bus pins are external: every pin input passes two flip-flops.
`timescale 1ns/1ns
module vpw_pci_master
  import vpw_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire vpw_req_t    req,
  output logic             done,
  output logic             err,
  output logic [31:0]      rdata,
  output logic             pci_req_n,
  input  wire logic        pci_gnt_n,
  input  wire logic [31:0] pci_ad_in,
  output logic [31:0]      pci_ad_out,
  output logic             pci_ad_oe,
  output logic [3:0]       pci_cbe_n_out,
  output logic             pci_frame_n_out,
  output logic             pci_irdy_n_out,
  output logic             pci_ctl_oe,
  input  wire logic        pci_frame_n_in,
  input  wire logic        pci_irdy_n_in,
  input  wire logic        pci_trdy_n_in,
  input  wire logic        pci_devsel_n_in,
  input  wire logic        pci_stop_n_in
);

  logic [37:0] s1_q;
  logic [37:0] s2_q;
  logic        gnt_s, frame_s, irdy_s, trdy_s, stop_s, devsel_s;
  logic [31:0] ad_s;

  vpw_state_t  st_q, st_d;
  vpw_req_t    lat_q, lat_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        done_d, err_d, req_n_d, frame_d, irdy_d, ad_oe_d, ctl_oe_d;
  logic [31:0] rdata_d, ad_d;
  logic [3:0]  cbe_d;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= {38{1'b1}};
      s2_q <= {38{1'b1}};
    end else begin
      s1_q <= {pci_ad_in, pci_gnt_n, pci_frame_n_in, pci_irdy_n_in, pci_trdy_n_in, pci_devsel_n_in, pci_stop_n_in};
      s2_q <= s1_q;
    end
  end

  assign {ad_s, gnt_s, frame_s, irdy_s, trdy_s, devsel_s, stop_s} = s2_q;

  // sampled data stays aligned with sampled trdy because both pass the same two stages;
  // limitation: irdy is held two cycles past the target's completing edge.
  always_comb begin
    st_d     = st_q;
    lat_d    = lat_q;
    cnt_d    = cnt_q;
    done_d   = 1'b0;
    err_d    = 1'b0;
    rdata_d  = rdata;
    req_n_d  = pci_req_n;
    frame_d  = pci_frame_n_out;
    irdy_d   = pci_irdy_n_out;
    ad_d     = pci_ad_out;
    ad_oe_d  = pci_ad_oe;
    cbe_d    = pci_cbe_n_out;
    ctl_oe_d = pci_ctl_oe;
    case (st_q)
      VPW_ST_IDLE: begin
        if (start) begin
          lat_d   = req;
          req_n_d = 1'b0;
          st_d    = VPW_ST_REQ;
        end
      end
      VPW_ST_REQ: begin
        if (!gnt_s && frame_s && irdy_s) begin
          frame_d  = 1'b0;
          ad_d     = lat_q.addr;
          cbe_d    = lat_q.cmd;
          ad_oe_d  = 1'b1;
          ctl_oe_d = 1'b1;
          st_d     = VPW_ST_ADDR;
        end
      end
      VPW_ST_ADDR: begin
        frame_d = 1'b1;
        irdy_d  = 1'b0;
        req_n_d = 1'b1;
        cbe_d   = lat_q.be_n;
        ad_d    = lat_q.wdata;
        ad_oe_d = lat_q.we;
        cnt_d   = 8'h00;
        st_d    = VPW_ST_DATA;
      end
      VPW_ST_DATA: begin
        cnt_d = cnt_q + 8'h01;
        if (!trdy_s && !devsel_s) begin
          rdata_d = ad_s;
          done_d  = 1'b1;
          irdy_d  = 1'b1;
          st_d    = VPW_ST_TURN;
        end else if (!stop_s || cnt_q == VPW_WAIT_CYCLES) begin
          // retry, target abort and master abort all end the access as an error
          err_d  = 1'b1;
          irdy_d = 1'b1;
          st_d   = VPW_ST_TURN;
        end
      end
      VPW_ST_TURN: begin
        ad_oe_d  = 1'b0;
        ctl_oe_d = 1'b0;
        st_d     = VPW_ST_IDLE;
      end
      default: begin
        st_d = VPW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q            <= VPW_ST_IDLE;
      lat_q           <= VPW_REQ_RST;
      cnt_q           <= 8'h00;
      done            <= 1'b0;
      err             <= 1'b0;
      rdata           <= 32'h0000_0000;
      pci_req_n       <= 1'b1;
      pci_frame_n_out <= 1'b1;
      pci_irdy_n_out  <= 1'b1;
      pci_ad_out      <= 32'h0000_0000;
      pci_ad_oe       <= 1'b0;
      pci_cbe_n_out   <= 4'hF;
      pci_ctl_oe      <= 1'b0;
    end else begin
      st_q            <= st_d;
      lat_q           <= lat_d;
      cnt_q           <= cnt_d;
      done            <= done_d;
      err             <= err_d;
      rdata           <= rdata_d;
      pci_req_n       <= req_n_d;
      pci_frame_n_out <= frame_d;
      pci_irdy_n_out  <= irdy_d;
      pci_ad_out      <= ad_d;
      pci_ad_oe       <= ad_oe_d;
      pci_cbe_n_out   <= cbe_d;
      pci_ctl_oe      <= ctl_oe_d;
    end
  end

endmodule // vpw_pci_master

// ### vpw_window.sv
// host-facing decode, window control register and master enable of the
// pci direct access window; assumes host requests come from same-clock logic.
`timescale 1ns/1ns
module vpw_window
  import vpw_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        host_req,
  input  wire logic        host_we,
  input  wire logic [31:0] host_addr,
  input  wire logic [1:0]  host_size,
  input  wire logic [31:0] host_wdata,
  output logic             host_ack,
  output logic             host_err,
  output logic [31:0]      host_rdata,
  input  wire logic        proc_men_wr,
  input  wire logic        proc_men_val,
  output logic             pci_req_n,
  input  wire logic        pci_gnt_n,
  input  wire logic [31:0] pci_ad_in,
  output logic [31:0]      pci_ad_out,
  output logic             pci_ad_oe,
  output logic [3:0]       pci_cbe_n_out,
  output logic             pci_frame_n_out,
  output logic             pci_irdy_n_out,
  output logic             pci_ctl_oe,
  input  wire logic        pci_frame_n_in,
  input  wire logic        pci_irdy_n_in,
  input  wire logic        pci_trdy_n_in,
  input  wire logic        pci_devsel_n_in,
  input  wire logic        pci_stop_n_in
);

  logic [31:0] ctrl_q, ctrl_d;
  logic        men_q, men_d;
  logic        busy_q, busy_d;
  logic        abort_q, abort_d;
  logic        start_q, start_d;
  vpw_req_t    req_q, req_d;
  logic        ack_d, err_d;
  logic [31:0] rdata_d;
  logic        eng_done, eng_err;
  logic [31:0] eng_rdata;
  logic        in_win;
  logic [31:0] pci_addr;
  logic        host_we_lat_q;

  // active-low lanes from host width and byte alignment
  function automatic logic [3:0] wr_be_n(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (size)
      VPW_SZ_BYTE: r = ~(4'h1 << a);
      VPW_SZ_WORD: r = a[1] ? 4'h3 : 4'hC;
      default:     r = 4'h0;
    endcase
    return r;
  endfunction

  // command code per type field and direction
  function automatic logic [3:0] cmd_of(input logic [1:0] typ, input logic we);
    logic [3:0] c;
    c = 4'h0;
    case (typ)
      2'h0:    c = we ? 4'h1 : 4'h0;
      2'h1:    c = we ? 4'h3 : 4'h2;
      2'h2:    c = we ? 4'h7 : 4'h6;
      default: c = we ? 4'hB : 4'hA;
    endcase
    return c;
  endfunction

  assign in_win = (host_addr[31:VPW_WIN_AW] == VPW_WIN_BASE[31:VPW_WIN_AW]);

  always_comb begin
    pci_addr = {ctrl_q[31:VPW_BASE_LSB], host_addr[VPW_WIN_AW-1:0]};
    if (ctrl_q[VPW_FORCE_BIT]) begin
      pci_addr[1:0] = ctrl_q[VPW_LOWA_LSB +: 2];
    end
  end

  // master enable: only the processor port reaches it, the host decode has no path to it
  always_comb begin
    men_d = men_q;
    if (proc_men_wr) begin
      men_d = proc_men_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      men_q <= VPW_MEN_RST;
    end else begin
      men_q <= men_d;
    end
  end

  // outcome of the last pci access, held for the status word until the next one ends
  always_comb begin
    abort_d = abort_q;
    if (busy_q && (eng_done || eng_err)) begin
      abort_d = eng_err;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    busy_d  = busy_q;
    start_d = 1'b0;
    req_d   = req_q;
    ack_d   = 1'b0;
    err_d   = 1'b0;
    rdata_d = host_rdata;
    if (busy_q) begin
      // requests arriving while a pci access runs are ignored until the ack
      if (eng_done || eng_err) begin
        busy_d  = 1'b0;
        ack_d   = 1'b1;
        err_d   = eng_err;
        rdata_d = host_we_lat_q ? 32'h0000_0000 : eng_rdata;
      end
    end else if (host_req && !host_ack) begin
      // the host holds its request through the ack cycle; taking it there would repeat the access
      ack_d   = 1'b1;
      rdata_d = 32'h0000_0000;
      if (host_addr == VPW_CTRL_OFS) begin
        if (host_we) begin
          ctrl_d = host_wdata & VPW_CTRL_MASK;
        end else begin
          rdata_d = ctrl_q;
        end
      end else if (host_addr == VPW_STAT_OFS) begin
        rdata_d = {30'h0, abort_q, men_q};
      end else if (in_win) begin
        if (men_q) begin
          ack_d      = 1'b0;
          busy_d     = 1'b1;
          start_d    = 1'b1;
          req_d.addr = pci_addr;
          req_d.cmd  = cmd_of(ctrl_q[VPW_TYPE_LSB +: 2], host_we);
          req_d.be_n = host_we ? wr_be_n(host_size, host_addr[1:0])
                               : ctrl_q[VPW_RBE_LSB +: 4];
          req_d.wdata = host_wdata;
          req_d.we   = host_we;
        end else begin
          err_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q        <= VPW_CTRL_RST;
      busy_q        <= 1'b0;
      start_q       <= 1'b0;
      req_q         <= VPW_REQ_RST;
      host_ack      <= 1'b0;
      host_err      <= 1'b0;
      host_rdata    <= 32'h0000_0000;
      host_we_lat_q <= 1'b0;
    end else begin
      ctrl_q        <= ctrl_d;
      busy_q        <= busy_d;
      start_q       <= start_d;
      req_q         <= req_d;
      host_ack      <= ack_d;
      host_err      <= err_d;
      host_rdata    <= rdata_d;
      host_we_lat_q <= req_d.we;
    end
  end

  vpw_pci_master u_master (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .start           (start_q),
    .req             (req_q),
    .done            (eng_done),
    .err             (eng_err),
    .rdata           (eng_rdata),
    .pci_req_n       (pci_req_n),
    .pci_gnt_n       (pci_gnt_n),
    .pci_ad_in       (pci_ad_in),
    .pci_ad_out      (pci_ad_out),
    .pci_ad_oe       (pci_ad_oe),
    .pci_cbe_n_out   (pci_cbe_n_out),
    .pci_frame_n_out (pci_frame_n_out),
    .pci_irdy_n_out  (pci_irdy_n_out),
    .pci_ctl_oe      (pci_ctl_oe),
    .pci_frame_n_in  (pci_frame_n_in),
    .pci_irdy_n_in   (pci_irdy_n_in),
    .pci_trdy_n_in   (pci_trdy_n_in),
    .pci_devsel_n_in (pci_devsel_n_in),
    .pci_stop_n_in   (pci_stop_n_in)
  );

endmodule // vpw_window

// ### vpw_window_props.sv
// assertions on the ports of the direct access window bridge.
// assumes the host holds address, size and direction until host_ack.
`timescale 1ns/1ns
module vpw_window_props
  import vpw_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        host_req,
  input wire logic        host_we,
  input wire logic [31:0] host_addr,
  input wire logic [1:0]  host_size,
  input wire logic [31:0] host_wdata,
  input wire logic        host_ack,
  input wire logic        host_err,
  input wire logic [31:0] host_rdata,
  input wire logic        proc_men_wr,
  input wire logic        proc_men_val,
  input wire logic        pci_req_n,
  input wire logic [31:0] pci_ad_out,
  input wire logic [3:0]  pci_cbe_n_out,
  input wire logic        pci_frame_n_out
);
  logic [31:0] ctl_q, ctl_d;
  logic        men_q, men_d;
  logic [2:0]  cmd_hi;
  logic [3:0]  wbe;
  always_comb begin
    ctl_d  = (host_ack && host_we && host_addr == VPW_CTRL_OFS) ? host_wdata & VPW_CTRL_MASK : ctl_q;
    men_d  = proc_men_wr ? proc_men_val : men_q;
    cmd_hi = (ctl_q[2:1] == 2'h3) ? 3'h5 : {1'b0, ctl_q[2], |ctl_q[2:1]};
    wbe    = (host_size == VPW_SZ_WORD) ? (host_addr[1] ? 4'h3 : 4'hC) : 4'h0;
    if (host_size == VPW_SZ_BYTE) wbe = ~(4'h1 << host_addr[1:0]);
  end
  always_ff @(posedge clk_sys) begin
    ctl_q <= rst ? VPW_CTRL_RST : ctl_d;
    men_q <= rst ? VPW_MEN_RST : men_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_addr_ph;
    $fell(pci_frame_n_out);
  endsequence
  property p_addr;
    s_addr_ph |-> pci_ad_out == {ctl_q[31:13], host_addr[12:2], (ctl_q[11] ? ctl_q[9:8] : host_addr[1:0])};
  endproperty
  a_addr: assert property (p_addr) else $error("address phase wrong");
  property p_cmd;
    s_addr_ph |-> pci_cbe_n_out == {cmd_hi, host_we};
  endproperty
  a_cmd: assert property (p_cmd) else $error("command wrong");
  property p_be;
    s_addr_ph |=> pci_cbe_n_out == (host_we ? wbe : ctl_q[7:4]);
  endproperty
  a_be: assert property (p_be) else $error("byte enables wrong");
  property p_frame_one;
    !pci_frame_n_out |=> pci_frame_n_out;
  endproperty
  a_frame_one: assert property (p_frame_one) else $error("frame longer than one cycle");
  property p_rd_back;
    host_ack && !host_we && host_addr == VPW_CTRL_OFS |-> host_rdata == ctl_q;
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("control readback wrong");
  property p_no_master;
    !men_q |-> pci_req_n;
  endproperty
  a_no_master: assert property (p_no_master) else $error("bus requested while disabled");
  property p_refuse;
    host_req && !host_ack && host_addr[31:13] == 19'h1 && !men_q |=> host_ack && host_err;
  endproperty
  a_refuse: assert property (p_refuse) else $error("disabled access not refused");
  property p_err_ack;
    host_err |-> host_ack;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("error without ack");
endmodule // vpw_window_props

bind vpw_window vpw_window_props u_props (.*);

// ### vpw_pci_tgt.sv
// pci arbiter and target model on the bridge's master pins.
// assumes one master; lat adds target wait states.
`timescale 1ns/1ns
module vpw_pci_tgt #(
  parameter logic [31:0] KEY = 32'h3C3C_A5A5
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [1:0]  lat,
  input  wire logic        pci_req_n,
  input  wire logic [31:0] pci_ad_out,
  input  wire logic        pci_ad_oe,
  input  wire logic [3:0]  pci_cbe_n_out,
  input  wire logic        pci_frame_n_out,
  input  wire logic        pci_irdy_n_out,
  input  wire logic        pci_ctl_oe,
  output logic             pci_gnt_n,
  output logic [31:0]      pci_ad_in,
  output logic             pci_frame_n_in,
  output logic             pci_irdy_n_in,
  output logic             pci_trdy_n_in,
  output logic             pci_devsel_n_in,
  output logic             pci_stop_n_in,
  output logic [31:0]      cap_addr,
  output logic [3:0]       cap_cmd,
  output logic [3:0]       cap_be,
  output logic [31:0]      cap_wdata,
  output logic [7:0]       n_frames
);
  logic [1:0] cnt_q;
  // an undriven ad bus shows the inverse of its last value, or cap_addr ^ KEY while trdy is asserted, never a stale copy
  assign pci_ad_in       = pci_ad_oe ? pci_ad_out : (pci_trdy_n_in ? ~pci_ad_out : cap_addr ^ KEY);
  assign pci_frame_n_in  = pci_ctl_oe ? pci_frame_n_out : 1'b1;
  assign pci_irdy_n_in   = pci_ctl_oe ? pci_irdy_n_out : 1'b1;
  assign pci_devsel_n_in = pci_trdy_n_in;
  assign pci_stop_n_in   = 1'b1;
  always @(posedge clk_sys) begin
    pci_gnt_n <= pci_req_n | rst;
    if (rst) begin
      pci_trdy_n_in <= 1'b1;
      n_frames      <= 8'h00;
    end else if (!pci_frame_n_in) begin
      cap_addr <= pci_ad_out;
      cap_cmd  <= pci_cbe_n_out;
      cnt_q    <= lat;
      n_frames <= n_frames + 8'h01;
    end else if (!pci_irdy_n_in) begin
      cap_be    <= pci_cbe_n_out;
      cap_wdata <= pci_ad_out;
      cnt_q     <= cnt_q - 2'h1;
      if (cnt_q == 2'h0) pci_trdy_n_in <= 1'b0;
    end else begin
      pci_trdy_n_in <= 1'b1;
    end
  end
endmodule // vpw_pci_tgt

// ### vpw_pci_direct_access_window_test.sv
// self-checking bench for the direct access window bridge.
// assumes the pci target model is the only device on the bus.
`timescale 1ns/1ns
module vxi_pci_direct_access_window_test
  import vpw_pkg::*;
;
  localparam logic [31:0] RD_KEY = 32'h3C3C_A5A5;
  localparam logic [3:0]  CMD_RD [4] = '{4'h0, 4'h2, 4'h6, 4'hA};
  logic        clk_sys = 1'b0, rst = 1'b1, host_req = 1'b0, host_we = 1'b0;
  logic        proc_men_wr = 1'b0, proc_men_val = 1'b0;
  logic [31:0] host_addr = 32'h0, host_wdata = 32'h0;
  logic [1:0]  host_size = 2'h0, lat = 2'h0, sz;
  logic        host_ack, host_err, pci_req_n, pci_gnt_n, pci_ad_oe, pci_ctl_oe, er, we;
  logic        pci_frame_n_out, pci_irdy_n_out, pci_frame_n_in, pci_irdy_n_in;
  logic        pci_trdy_n_in, pci_devsel_n_in, pci_stop_n_in;
  logic [31:0] host_rdata, pci_ad_out, pci_ad_in, cap_addr, cap_wdata, rd, ctl, a, d;
  logic [3:0]  pci_cbe_n_out, cap_cmd, cap_be;
  logic [7:0]  n_frames, frames;
  int          err_total = 0, num_checks = 0, cyc = 0;

  vpw_window uut (.*);
  vpw_pci_tgt #(.KEY(RD_KEY)) u_tgt (.*);

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request and its qualifiers stand until the edge that samples ack high; answer taken there
  task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] wd, input logic [1:0] s);
    int n = 0;
    @(posedge clk_sys);
    host_req   <= 1'b1;
    host_we    <= w;
    host_addr  <= ad;
    host_wdata <= wd;
    host_size  <= s;
    do begin
      @(posedge clk_sys);
      n++;
    end while (host_ack !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_total++;
      tally_and_finish();
    end
    rd = host_rdata;
    er = host_err;
    host_req <= 1'b0;
  endtask
  task automatic set_men(input logic v);
    @(posedge clk_sys);
    proc_men_wr  <= 1'b1;
    proc_men_val <= v;
    @(posedge clk_sys);
    proc_men_wr <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] pci_addr(logic [31:0] c, logic [31:0] x);
    return {c[31:13], x[12:2], (c[11] ? c[9:8] : x[1:0])};
  endfunction
  function automatic logic [3:0] wr_be(logic [31:0] x, logic [1:0] s);
    if (s == VPW_SZ_BYTE) return ~(4'h1 << x[1:0]);
    if (s == VPW_SZ_WORD) return x[1] ? 4'h3 : 4'hC;
    return 4'h0;
  endfunction

  initial begin
    rd = $urandom(30510);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    acc(1'b0, VPW_CTRL_OFS, 32'h0, VPW_SZ_LONG);
    chk("ctrl_reset", rd, VPW_CTRL_RST);
    acc(1'b0, VPW_STAT_OFS, 32'h0, VPW_SZ_LONG);
    chk("men_reset", rd & 32'h1, 32'h1);
    acc(1'b0, 32'h0000_1000, 32'h0, VPW_SZ_LONG);
    chk("unmapped", rd | er, 32'h0);
    repeat (4) begin
      d = $urandom;
      acc(1'b1, VPW_CTRL_OFS, d, VPW_SZ_LONG);
      acc(1'b0, VPW_CTRL_OFS, 32'h0, VPW_SZ_LONG);
      chk("ctrl_rb", rd, d & VPW_CTRL_MASK);
    end
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      ctl = $urandom & VPW_CTRL_MASK;
      ctl[2:1] = i[1:0];
      // one select bit, no forcing: a type 0 configuration access
      if (i == 3) ctl = (32'h1 << (13 + $urandom % 19)) | 32'h6;
      we = i[2];
      acc(1'b1, VPW_CTRL_OFS, ctl, VPW_SZ_LONG);
      repeat (2) begin
        lat <= 2'($urandom);
        a = VPW_WIN_BASE | ($urandom & 32'h1FFF);
        d = $urandom;
        sz = 2'($urandom % 3);
        acc(we, a, d, sz);
        chk("pci_addr", cap_addr, pci_addr(ctl, a));
        chk("pci_cmd", cap_cmd, CMD_RD[i[1:0]] | we);
        chk("pci_be", cap_be, we ? wr_be(a, sz) : ctl[7:4]);
        chk("data", we ? cap_wdata : rd, we ? d : pci_addr(ctl, a) ^ RD_KEY);
      end
    end
    $display("test window done");
    set_men(1'b0);
    acc(1'b1, VPW_STAT_OFS, 32'hFFFF_FFFF, VPW_SZ_LONG);
    acc(1'b0, VPW_STAT_OFS, 32'h0, VPW_SZ_LONG);
    chk("men_clear", rd & 32'h1, 32'h0);
    frames = n_frames;
    acc(1'b0, VPW_WIN_BASE, 32'h0, VPW_SZ_LONG);
    chk("refused", {er, n_frames}, {1'b1, frames});
    set_men(1'b1);
    acc(1'b0, VPW_WIN_BASE, 32'h0, VPW_SZ_LONG);
    chk("reenabled", {er, n_frames}, {1'b0, frames + 8'h01});
    $display("test master enable done");
    tally_and_finish();
  end
endmodule // vxi_pci_direct_access_window_test
